// File: pmu_seq_cfg.svh
// Purpose: constants for the power mode sequencer
// Assumes: 250 MHz system clock
// Notes:   rail n is bit n-1 of the rail vector
`ifndef PMU_SEQ_CFG_SVH
`define PMU_SEQ_CFG_SVH

`define CLK_MHZ            250
`define SLOT_STEP_US       100
`define SLOT_STEP_CYC      (`SLOT_STEP_US * `CLK_MHZ)
`define DEBOUNCE_US        20
`define DEBOUNCE_CYC       (`DEBOUNCE_US * `CLK_MHZ)
`define RAIL_COUNT         13
`define SLOT_LAST          3'h6
`define SLEEP_MASK         13'h1_6BB
`define STANDBY_MASK       13'h1_000
`define ALL_ON_MASK        13'h1_FFF
`define ALL_OFF_MASK       13'h0_000
`define CORE_RAIL_MASK     13'h0_004
// slot masks: slot k holds the rails enabled at step k
`define SLOT0_MASK         13'h1_000
`define SLOT1_MASK         13'h0_340
`define SLOT2_MASK         13'h0_030
`define SLOT3_MASK         13'h0_408
`define SLOT4_MASK         13'h0_004
`define SLOT5_MASK         13'h0_003
`define SLOT6_MASK         13'h0_080
`define RAIL12_MASK        13'h0_800
// led: one step of the base rate at code 000 is 4 s / 16 duty steps
`define LED_BASE_MS        4000
`define LED_STEP_CYC       ((`LED_BASE_MS * 1000 * `CLK_MHZ) / 16)

`endif

// File: pmu_seq_pkg.sv
// Purpose: types for the power mode sequencer
// Assumes: nothing
// Notes:   constants live in pmu_seq_cfg.svh
package pmu_seq_pkg;
    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_RAMP    = 3'b001,
        ST_ON      = 3'b010,
        ST_SLEEP   = 3'b011,
        ST_STANDBY = 3'b100
    } mode_t;
endpackage : pmu_seq_pkg

// File: led_pwm.sv
// Purpose: low-rate led pwm with rate and duty select
// Assumes: step_cyc is one duty step at rate code 000
// Notes:   rate code n halves the period n times
`timescale 1ns/1ps
module led_pwm #(
    parameter int unsigned STEP_CYC = 62_500_000
) (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic [2:0] rate_i,
    input  wire logic [3:0] duty_i,
    output logic            led_o
);
    typedef struct packed {
        logic [31:0] div;
        logic [3:0]  phase;
        logic        led;
    } pwm_t;
    pwm_t s_r, s_nxt;
    logic [31:0] lim;

    always_comb begin
        lim   = (32'(STEP_CYC) >> rate_i) - 32'h0000_0001; // RQ1
        s_nxt = s_r;
        if (s_r.div >= lim) begin
            s_nxt.div   = 32'h0000_0000;
            s_nxt.phase = s_r.phase + 4'h1;
        end else begin
            s_nxt.div = s_r.div + 32'h0000_0001;
        end
        // duty code d gives (d+1)/16 on-time: 0000 is 6.25 %, 1111 full on
        s_nxt.led = (s_nxt.phase <= duty_i); // RQ1
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) s_r <= '0;
        else         s_r <= s_nxt;
    end

    assign led_o = s_r.led;
endmodule : led_pwm

// File: pmu_power_mode_sequencer.sv
// Purpose: power mode selection, rail sequencing and led pwm
// Assumes: pins are asynchronous, clock 250 MHz
// Notes:   rails are enable outputs, bit n-1 is rail n
// Overview of operation
// RQ1: led pwm: 3-bit rate, 4-bit duty
// RQ2: hold and enable high: all rails on
// RQ3: hold high, enable low: sleep mode
// RQ4: sleep keeps rails 1,2,4,5,6,8,10,11,13
// RQ5: standby keeps only always-on rail 13
// RQ6: both low, aux low: all rails off
// RQ7: power-up enables rails by ascending slot
// RQ8: processor asserts hold before button release
// RQ9: button or enable wakes sleep, core rail
// RQ10: hold and enable synchronised and debounced
`timescale 1ns/1ps
`include "pmu_seq_cfg.svh"
module pmu_power_mode_sequencer
    import pmu_seq_pkg::*;
#(
    parameter int unsigned SLOT_STEP_CYC = `SLOT_STEP_CYC,
    parameter int unsigned DEBOUNCE_CYC  = `DEBOUNCE_CYC,
    parameter int unsigned LED_STEP_CYC  = `LED_STEP_CYC
) (
    input  wire logic        CLOCK_I,
    input  wire logic        RSTN_I,
    input  wire logic        SYS_HOLD_IN_I,
    input  wire logic        RUN_ENABLE_IN_I,
    input  wire logic        PUSH_BUTTON_IN_N_I,
    input  wire logic        AUX_SUPPLY_LEVEL_OK_I,
    input  wire logic [2:0]  LED_RATE_SEL_I,
    input  wire logic [3:0]  LED_DUTY_SEL_I,
    output logic [12:0]      RAIL_EN_O,
    output logic [2:0]       MODE_O,
    output logic             BUTTON_STATE_OUT_N_O,
    output logic             LED_O
);
    typedef struct packed {
        logic [1:0]  hold_sy;
        logic [1:0]  en_sy;
        logic [1:0]  pb_sy;
        logic [1:0]  aux_sy;
        logic        hold_db;
        logic        en_db;
        logic [31:0] db_cnt;
        mode_t       mode;
        logic [2:0]  slot;
        logic [31:0] slot_cnt;
        logic [12:0] rails;
        logic        pb_stat_n;
    } seq_t;
    seq_t s_r, s_nxt;

    function automatic logic [12:0] slot_mask(input logic [2:0] k);
        logic [12:0] m;
        m = `ALL_OFF_MASK;
        unique case (k)
            3'h0: m = `SLOT0_MASK;
            3'h1: m = `SLOT1_MASK;
            3'h2: m = `SLOT2_MASK;
            3'h3: m = `SLOT3_MASK;
            3'h4: m = `SLOT4_MASK;
            3'h5: m = `SLOT5_MASK;
            3'h6: m = `SLOT6_MASK;
            default: m = `ALL_OFF_MASK;
        endcase
        return m;
    endfunction : slot_mask

    logic pb_pressed;
    logic aux_ok;
    logic led_q;

    always_comb begin
        s_nxt = s_r;
        // second stage only feeds logic; first stage feeds the second alone
        s_nxt.hold_sy = {s_r.hold_sy[0], SYS_HOLD_IN_I}; // RQ10
        s_nxt.en_sy   = {s_r.en_sy[0], RUN_ENABLE_IN_I}; // RQ10
        s_nxt.pb_sy   = {s_r.pb_sy[0], PUSH_BUTTON_IN_N_I};
        s_nxt.aux_sy  = {s_r.aux_sy[0], AUX_SUPPLY_LEVEL_OK_I};
        pb_pressed    = !s_r.pb_sy[1];
        aux_ok        = s_r.aux_sy[1];
        // debounce: either one differing for the full window loads both
        if (s_r.hold_sy[1] != s_r.hold_db || s_r.en_sy[1] != s_r.en_db) begin
            if (s_r.db_cnt >= 32'(DEBOUNCE_CYC) - 32'h0000_0001) begin // RQ10
                s_nxt.hold_db = s_r.hold_sy[1];
                s_nxt.en_db   = s_r.en_sy[1];
                s_nxt.db_cnt  = 32'h0000_0000;
            end else begin
                s_nxt.db_cnt = s_r.db_cnt + 32'h0000_0001;
            end
        end else begin
            s_nxt.db_cnt = 32'h0000_0000;
        end
        s_nxt.pb_stat_n = !pb_pressed;
        unique case (s_r.mode)
            ST_OFF: begin
                s_nxt.rails = `ALL_OFF_MASK; // RQ6
                if (pb_pressed) begin
                    s_nxt.mode     = ST_RAMP;
                    s_nxt.slot     = 3'h0;
                    s_nxt.slot_cnt = 32'h0000_0000;
                    s_nxt.rails    = slot_mask(3'h0); // RQ7
                end else if (aux_ok) begin
                    s_nxt.mode  = ST_STANDBY;
                    s_nxt.rails = `STANDBY_MASK; // RQ5
                end
            end
            ST_STANDBY: begin
                s_nxt.rails = `STANDBY_MASK; // RQ5
                if (pb_pressed) begin
                    s_nxt.mode     = ST_RAMP;
                    s_nxt.slot     = 3'h0;
                    s_nxt.slot_cnt = 32'h0000_0000;
                end else if (!aux_ok) begin
                    s_nxt.mode  = ST_OFF;
                    s_nxt.rails = `ALL_OFF_MASK; // RQ6
                end
            end
            ST_RAMP: begin
                if (!pb_pressed && !s_r.hold_db) begin
                    // released before hold: abandon power-up
                    s_nxt.mode  = ST_OFF;
                    s_nxt.rails = `ALL_OFF_MASK; // RQ8
                end else if (s_r.slot_cnt >= 32'(SLOT_STEP_CYC) - 32'h0000_0001) begin
                    s_nxt.slot_cnt = 32'h0000_0000;
                    if (s_r.slot == `SLOT_LAST) begin
                        s_nxt.mode  = ST_ON;
                        s_nxt.rails = s_r.rails | `RAIL12_MASK; // RQ2
                    end else begin
                        s_nxt.slot  = s_r.slot + 3'h1;
                        s_nxt.rails = s_r.rails | slot_mask(s_r.slot + 3'h1); // RQ7
                    end
                end else begin
                    s_nxt.slot_cnt = s_r.slot_cnt + 32'h0000_0001;
                end
            end
            ST_ON: begin
                s_nxt.rails = `ALL_ON_MASK; // RQ2
                if (!s_r.hold_db) begin
                    s_nxt.mode  = aux_ok ? ST_STANDBY : ST_OFF;
                    s_nxt.rails = aux_ok ? `STANDBY_MASK : `ALL_OFF_MASK; // RQ5 RQ6
                end else if (!s_r.en_db) begin
                    s_nxt.mode  = ST_SLEEP; // RQ3
                    s_nxt.rails = `SLEEP_MASK; // RQ4
                end
            end
            ST_SLEEP: begin
                s_nxt.rails = `SLEEP_MASK; // RQ4
                if (!s_r.hold_db) begin
                    s_nxt.mode  = aux_ok ? ST_STANDBY : ST_OFF;
                    s_nxt.rails = aux_ok ? `STANDBY_MASK : `ALL_OFF_MASK; // RQ5 RQ6
                end else if (pb_pressed || s_r.en_db) begin
                    // wake restores the core rail and the rest of full-on
                    s_nxt.mode  = ST_ON; // RQ9
                    s_nxt.rails = `ALL_ON_MASK | `CORE_RAIL_MASK; // RQ9
                end
            end
            default: begin
                s_nxt.mode  = ST_OFF;
                s_nxt.rails = `ALL_OFF_MASK;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            s_r           <= '0;
            s_r.pb_sy     <= 2'h3;
            s_r.pb_stat_n <= 1'b1;
            s_r.mode      <= ST_OFF;
        end else begin
            s_r <= s_nxt;
        end
    end

    led_pwm #(
        .STEP_CYC (LED_STEP_CYC)
    ) u_led (
        .clk_i  (CLOCK_I),
        .rstn_i (RSTN_I),
        .rate_i (LED_RATE_SEL_I),
        .duty_i (LED_DUTY_SEL_I),
        .led_o  (led_q)
    );

    assign RAIL_EN_O            = s_r.rails;
    assign MODE_O               = s_r.mode;
    assign BUTTON_STATE_OUT_N_O = s_r.pb_stat_n;
    assign LED_O                = led_q;
endmodule : pmu_power_mode_sequencer

// File: pmu_power_mode_sequencer_assertions.sv
// Purpose: port checks for the power mode sequencer
// Assumes: slot step of at least 4 cycles
// Notes:   bound to every sequencer instance
`timescale 1ns/1ps
module pmu_seq_checker #(
    parameter int unsigned SLOT_STEP_CYC = 4,
    parameter int unsigned DEBOUNCE_CYC  = 3,
    parameter int unsigned LED_STEP_CYC  = 16
) (
    input wire logic        CLOCK_I,
    input wire logic        RSTN_I,
    input wire logic        SYS_HOLD_IN_I,
    input wire logic        RUN_ENABLE_IN_I,
    input wire logic        PUSH_BUTTON_IN_N_I,
    input wire logic        AUX_SUPPLY_LEVEL_OK_I,
    input wire logic [2:0]  LED_RATE_SEL_I,
    input wire logic [3:0]  LED_DUTY_SEL_I,
    input wire logic [12:0] RAIL_EN_O,
    input wire logic [2:0]  MODE_O,
    input wire logic        BUTTON_STATE_OUT_N_O,
    input wire logic        LED_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);
    sequence s_ramp_entry; MODE_O == 3'h1 && $past(MODE_O) != 3'h1; endsequence
    sequence s_step; MODE_O == 3'h1 && $changed(RAIL_EN_O); endsequence
    sequence s_sleep_entry; MODE_O == 3'h3 && $past(MODE_O) == 3'h2; endsequence
    a_ramp_start: assert property (s_ramp_entry |-> RAIL_EN_O == 13'h1_000)
        else $error("ramp did not start with the always-on rail");
    // repetition of 3 assumes the slot step is at least 4 cycles
    a_slot_spacing: assert property (s_step |=> (MODE_O != 3'h1 || $stable(RAIL_EN_O))[*3])
        else $error("ramp slots too close together");
    a_full_on: assert property (MODE_O == 3'h2 |-> RAIL_EN_O == 13'h1_FFF)
        else $error("full-on mode without all rails");
    a_sleep_rails: assert property (MODE_O == 3'h3 |-> RAIL_EN_O == 13'h1_6BB)
        else $error("wrong rail set in sleep");
    a_standby_rail: assert property (MODE_O == 3'h4 |-> RAIL_EN_O == 13'h1_000)
        else $error("wrong rail set in standby");
    a_off_dark: assert property (MODE_O == 3'h0 |-> RAIL_EN_O == 13'h0_000)
        else $error("rails on while off");
    a_sleep_debounced: assert property (s_sleep_entry |->
        !$past(RUN_ENABLE_IN_I, 3) && !$past(RUN_ENABLE_IN_I, 5))
        else $error("sleep entered without a settled enable");
    a_button_wake: assert property (MODE_O == 3'h3 && !PUSH_BUTTON_IN_N_I && SYS_HOLD_IN_I
        |-> ##[1:6] MODE_O == 3'h2)
        else $error("button did not wake from sleep");
endmodule : pmu_seq_checker

bind pmu_power_mode_sequencer pmu_seq_checker #(.SLOT_STEP_CYC(SLOT_STEP_CYC),
    .DEBOUNCE_CYC(DEBOUNCE_CYC), .LED_STEP_CYC(LED_STEP_CYC)) chk (
    .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .SYS_HOLD_IN_I(SYS_HOLD_IN_I),
    .RUN_ENABLE_IN_I(RUN_ENABLE_IN_I), .PUSH_BUTTON_IN_N_I(PUSH_BUTTON_IN_N_I),
    .AUX_SUPPLY_LEVEL_OK_I(AUX_SUPPLY_LEVEL_OK_I), .LED_RATE_SEL_I(LED_RATE_SEL_I),
    .LED_DUTY_SEL_I(LED_DUTY_SEL_I), .RAIL_EN_O(RAIL_EN_O), .MODE_O(MODE_O),
    .BUTTON_STATE_OUT_N_O(BUTTON_STATE_OUT_N_O), .LED_O(LED_O));

// File: proc_model.sv
// Purpose: processor side driving hold and run enable
// Assumes: boot_i high means the boot succeeds
// Notes:   dly_i sets how slowly hold answers a press
`timescale 1ns/1ps
module proc_model (
    input  wire logic       clk_i,
    input  wire logic       boot_i,
    input  wire logic       run_i,
    input  wire logic [3:0] dly_i,
    input  wire logic       button_n_i,
    output logic            hold_o,
    output logic            run_o
);
    logic [3:0] cnt_r = 4'h0;
    initial hold_o = 1'b0;
    initial run_o = 1'b0;
    always @(posedge clk_i) begin
        run_o <= run_i;
        cnt_r <= button_n_i ? 4'h0 : cnt_r + 4'h1;
        if (!boot_i) hold_o <= 1'b0;
        else if (cnt_r == dly_i) hold_o <= 1'b1;
    end
endmodule : proc_model

// File: testbench.sv
// Purpose: self-checking bench for the power mode sequencer
// Assumes: shortened slot, debounce and led step counts
// Notes:   led step of 128 keeps every rate code at a step of one cycle or more
`timescale 1ns/1ps
module testbench;
    localparam int unsigned LSTEP = 128;
    logic        clk, rstn, boot, run, pb_n, aux, hold, run_en, btn_n, led;
    logic [3:0]  dly, duty;
    logic [2:0]  rate, mode;
    logic [12:0] rails;
    int          err_total = 0, checks = 0, cyc_cnt = 0, n, e;
    logic [12:0] ramp_q [7] = '{13'h1_000, 13'h1_340, 13'h1_370, 13'h1_778,
                                13'h1_77C, 13'h1_77F, 13'h1_7FF};
    pmu_power_mode_sequencer #(.SLOT_STEP_CYC(4), .DEBOUNCE_CYC(3), .LED_STEP_CYC(LSTEP)) uut (
        .CLOCK_I(clk), .RSTN_I(rstn), .SYS_HOLD_IN_I(hold), .RUN_ENABLE_IN_I(run_en),
        .PUSH_BUTTON_IN_N_I(pb_n), .AUX_SUPPLY_LEVEL_OK_I(aux), .LED_RATE_SEL_I(rate),
        .LED_DUTY_SEL_I(duty), .RAIL_EN_O(rails), .MODE_O(mode),
        .BUTTON_STATE_OUT_N_O(btn_n), .LED_O(led));
    proc_model u_proc (.clk_i(clk), .boot_i(boot), .run_i(run), .dly_i(dly),
        .button_n_i(btn_n), .hold_o(hold), .run_o(run_en));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic report_and_stop;
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        checks++;
        if (got !== ex) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic wait_mode(input logic [2:0] m, input logic [12:0] r);
        for (int i = 0; i < 300 && mode !== m; i++) tick(1);
        chk("mode", {13'h0, m}, {13'h0, mode});
        chk("rails", {3'h0, r}, {3'h0, rails});
    endtask : wait_mode
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 50000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'h625e269c));
        {rstn, boot, run, aux} = 4'h0;
        {pb_n, dly, rate, duty} = {1'b1, 4'h2, 3'h0, 4'h0};
        tick(12);
        wait_mode(3'h0, 13'h0_000);
        chk("button", 16'h0001, {15'h0, btn_n});
        rstn = 1'b1;
        tick(2);
        pb_n = 1'b0;
        wait_mode(3'h1, 13'h1_000);
        chk("button", 16'h0000, {15'h0, btn_n});
        tick(6);
        pb_n = 1'b1;
        wait_mode(3'h0, 13'h0_000);
        chk("button", 16'h0001, {15'h0, btn_n});
        {boot, run} = 2'b11;
        dly = 4'($urandom_range(1, 6));
        tick(10);
        pb_n = 1'b0;
        wait_mode(3'h1, 13'h1_000);
        for (int k = 1; k < 7; k++) begin
            for (n = 0; n < 20 && rails === ramp_q[k-1]; n++) tick(1);
            chk("rails", {3'h0, ramp_q[k]}, {3'h0, rails});
        end
        wait_mode(3'h2, 13'h1_FFF);
        pb_n = 1'b1;
        tick(8);
        run = 1'b0;
        tick(2);
        run = 1'b1;
        // a short enable drop must never reach the mode, not even for a cycle
        n = 0;
        repeat (12) begin
            tick(1);
            n += (mode !== 3'h2);
        end
        chk("glitch", 16'h0000, 16'(n));
        wait_mode(3'h2, 13'h1_FFF);
        for (int w = 0; w < 2; w++) begin
            run = 1'b0;
            wait_mode(3'h3, 13'h1_6BB);
            if (w == 0) run = 1'b1;
            else pb_n = 1'b0;
            wait_mode(3'h2, 13'h1_FFF);
            {pb_n, run} = 2'b11;
            tick(20);
        end
        for (int i = 0; i < 6; i++) begin
            rate = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom_range(0, 7));
            duty = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom_range(0, 15));
            e = 16 * (LSTEP >> rate);
            tick(2 * e);
            n = 0;
            repeat (e) begin
                tick(1);
                n += (led === 1'b1);
            end
            chk("led_on", 16'((duty + 1) * (LSTEP >> rate)), 16'(n));
        end
        {aux, boot, run} = 3'b100;
        wait_mode(3'h4, 13'h1_000);
        aux = 1'b0;
        wait_mode(3'h0, 13'h0_000);
        report_and_stop();
    end
endmodule : testbench
